/* File: dv/ivp_core_model.sv */
// Purpose: core side that takes offered vectors
// Assumes: an offer stands until acknowledged
// Notes:   waits dly_in cycles, then acks for one edge
`include "ivp_regs.svh"
module ivp_core_model
  import ivp_pkg::*;
(
  // clock and reset
  input  wire logic      clk_sys_in,
  input  wire logic      rst_b_in,
  // offer side
  input  wire logic      irq_in,
  input  wire ivp_vec_t  vec_in,
  input  wire ivp_lvl_t  lvl_in,
  input  wire ivp_addr_t addr_in,
  input  wire ivp_addr_t base_in,
  input  wire logic [1:0] dly_in,
  output logic           ack_out,
  // last fetch
  output logic           got_out,
  output logic           got_jump_out,
  output ivp_vec_t       got_vec_out,
  output ivp_lvl_t       got_lvl_out,
  output ivp_addr_t      got_addr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt;
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ack_out <= 1'b0;
      got_out <= 1'b0;
      got_jump_out <= 1'b0;
      cnt <= 2'h0;
      got_vec_out <= '0;
      got_lvl_out <= '0;
      got_addr_out <= '0;
    end
    else if (ack_out)
    begin
      // entries 0 and 1 hold jumps, the rest calls
      ack_out <= 1'b0;
      got_out <= 1'b1;
      got_jump_out <= (addr_in - base_in) <
                      `IVP_ADDR_W'(2 * `IVP_ENTRY_WORDS);
      cnt <= 2'h0;
      got_vec_out <= vec_in;
      got_lvl_out <= lvl_in;
      got_addr_out <= addr_in;
    end
    else
    begin
      got_out <= 1'b0;
      if (irq_in && cnt == dly_in)
        ack_out <= 1'b1;
      else if (irq_in)
        cnt <= cnt + 2'h1;
    end
  end
endmodule

/* File: dv/tb_top.sv */
// Purpose: self-checking bench for ivp_ctrl
// Assumes: core model acks each offer
// Notes:   one task per scenario
`include "ivp_regs.svh"
module tb_top
  import ivp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(nm, ex, sn) begin comparisons++; if ((sn) !== (ex)) begin \
    n_errors++; $display("unexpected %s exp %h got %h", nm, ex, sn); end end
  logic        clk_sys_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        clk_en_in = 1'b1;
  ivp_addr_t   vector_base_in = 21'h000000;
  logic [33:0] prog_lvl_in = 34'h0;
  logic [16:0] req_in = 17'h0;
  logic        chip_rst_req_in = 1'b0;
  logic        wdog_rst_req_in = 1'b0;
  logic [1:0]  dly = 2'h0;
  logic        ack, irq_out, ack_vec_out, got, got_jump;
  ivp_vec_t    vec_out, got_vec;
  ivp_lvl_t    lvl_out, got_lvl;
  ivp_addr_t   entry_addr_out, got_addr;
  int          n_errors = 0;
  int          comparisons = 0;

  ivp_ctrl DUT (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in), .vector_base_in(vector_base_in),
    .prog_lvl_in(prog_lvl_in), .req_in(req_in),
    .chip_rst_req_in(chip_rst_req_in), .wdog_rst_req_in(wdog_rst_req_in),
    .ack_in(ack), .irq_out(irq_out), .vec_out(vec_out), .lvl_out(lvl_out),
    .entry_addr_out(entry_addr_out), .ack_vec_out(ack_vec_out));
  ivp_core_model core (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .irq_in(irq_out), .vec_in(vec_out), .lvl_in(lvl_out),
    .addr_in(entry_addr_out), .base_in(vector_base_in),
    .dly_in(dly), .ack_out(ack), .got_jump_out(got_jump),
    .got_out(got), .got_vec_out(got_vec), .got_lvl_out(got_lvl),
    .got_addr_out(got_addr));

  initial
  begin
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // waits for the fetch, then the source drops its request
  task automatic serve(input int v, input ivp_lvl_t l);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (got !== 1'b1 && n < 40);
    `CHK("fetch", 1'b1, got)
    `CHK("ack_vec", 1'b1, ack_vec_out)
    `CHK("vector", 5'(v), got_vec)
    `CHK("level", l, got_lvl)
    `CHK("entry", vector_base_in + 21'(2 * v), got_addr)
    `CHK("entry_kind", (v < 2), got_jump)
    req_in[v] <= 1'b0;
    if (v == 0)
      chip_rst_req_in <= 1'b0;
    if (v == 1)
      wdog_rst_req_in <= 1'b0;
  endtask

  task automatic t_fixed;
    vector_base_in <= 21'h001000;
    req_in[5:2] <= 4'hF;
    for (int v = 2; v <= 5; v++)
      serve(v, 2'h3);
    $display("test fixed done");
  endtask

  task automatic t_order;
    vector_base_in <= 21'h1FFF00;
    dly <= 2'h2;
    prog_lvl_in[15:14] <= 2'h3;
    prog_lvl_in[13:12] <= 2'h2;
    prog_lvl_in[19:18] <= 2'h2;
    req_in <= 17'h03AC0;
    serve(7, 2'h3);
    serve(6, 2'h2);
    serve(9, 2'h2);
    serve(11, 2'h2);
    serve(12, 2'h1);
    serve(13, 2'h0);
    $display("test order done");
  endtask

  task automatic t_prog;
    dly <= 2'h0;
    prog_lvl_in[31:30] <= 2'h0;
    prog_lvl_in[33:32] <= 2'h3;
    prog_lvl_in[21:20] <= 2'h1;
    req_in <= 17'h19400;
    serve(16, 2'h3);
    serve(10, 2'h1);
    serve(12, 2'h1);
    serve(15, 2'h1);
    $display("test prog done");
  endtask

  task automatic t_rst_cause;
    chip_rst_req_in <= 1'b1;
    wdog_rst_req_in <= 1'b1;
    req_in <= 17'h04007;
    serve(0, 2'h3);
    serve(1, 2'h3);
    // overlay bits pending again: they must never be offered
    req_in[1:0] <= 2'h3;
    serve(2, 2'h3);
    repeat (8) @(posedge clk_sys_in);
    `CHK("irq_idle", 1'b0, irq_out)
    req_in <= 17'h0;
    $display("test reset causes done");
  endtask

  task automatic t_freeze;
    clk_en_in <= 1'b0;
    req_in[3] <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    `CHK("irq_frozen", 1'b0, irq_out)
    clk_en_in <= 1'b1;
    serve(3, 2'h3);
    $display("test freeze done");
  endtask

  // long enough for all tests with slow acks
  initial
  begin
    #(3000 * 50);
    n_errors++;
    summarize();
  end

  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    `CHK("irq_rst", 1'b0, irq_out)
    `CHK("entry_rst", `IVP_BASE_RESET, entry_addr_out)
    rst_b_in <= 1'b1;
    t_fixed();
    t_order();
    t_prog();
    t_rst_cause();
    t_freeze();
    summarize();
  end
endmodule

/* File: hw/ivp_arbiter.sv */
// Purpose: combinational winner search over pending sources
// Assumes: levels already resolved per vector
// Notes:   a linear scan; fine for 17 sources at 20 MHz
`include "ivp_regs.svh"
module ivp_arbiter
  import ivp_pkg::*;
#(
  parameter int NUM_VEC = `IVP_NUM_VEC
)
(
  // inputs
  input  wire logic [NUM_VEC-1:0]           pend_in,
  input  wire logic [NUM_VEC*`IVP_LVL_W-1:0] lvl_in,
  // result
  output logic                              hit_out,
  output ivp_vec_t                          vec_out,
  output ivp_lvl_t                          lvl_out
);
  always_comb
  begin
    hit_out = 1'b0;
    vec_out = '0;
    lvl_out = '0;
    // scan from the highest vector down so the lowest number wins ties
    for (int i = NUM_VEC - 1; i >= 0; i--)
    begin
      if (pend_in[i] &&
          (!hit_out || lvl_in[i*`IVP_LVL_W +: `IVP_LVL_W] >= lvl_out))
      begin
        hit_out = 1'b1;
        vec_out = i[`IVP_VEC_W-1:0];
        lvl_out = lvl_in[i*`IVP_LVL_W +: `IVP_LVL_W];
      end
    end
  end
endmodule

/* File: hw/ivp_ctrl.sv */
// Purpose: priority resolution and vector entry addressing for the core
// Assumes: requests are synchronous levels held until acknowledged
// Notes:   level and base inputs are static configuration from the core
`include "ivp_regs.svh"
module ivp_ctrl
  import ivp_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_sys_in,
  input  wire logic                   rst_b_in,
  input  wire logic                   clk_en_in,
  // configuration
  input  wire logic [`IVP_ADDR_W-1:0] vector_base_in,
  input  wire logic [`IVP_NUM_VEC*`IVP_LVL_W-1:0] prog_lvl_in,
  // sources and core reset causes
  input  wire logic [`IVP_NUM_VEC-1:0] req_in,
  input  wire logic                   chip_rst_req_in,
  input  wire logic                   wdog_rst_req_in,
  // core side
  input  wire logic                   ack_in,
  output logic                        irq_out,
  output logic [`IVP_VEC_W-1:0]       vec_out,
  output logic [`IVP_LVL_W-1:0]       lvl_out,
  output logic [`IVP_ADDR_W-1:0]      entry_addr_out,
  output logic                        ack_vec_out
);
  logic [`IVP_NUM_VEC-1:0]             src_mask;
  logic [`IVP_NUM_VEC-1:0]             pend;
  logic [`IVP_NUM_VEC*`IVP_LVL_W-1:0]  eff_lvl;
  logic                                hit;
  ivp_vec_t                            win_vec;
  ivp_lvl_t                            win_lvl;
  ivp_state_t                          state;
  ivp_state_t                          next_state;
  logic                                next_irq;
  ivp_vec_t                            next_vec;
  ivp_lvl_t                            next_lvl;
  ivp_addr_t                           next_addr;
  logic                                next_ack_vec;

  // per-vector level and legality
  for (genvar v = 0; v < `IVP_NUM_VEC; v++)
  begin : g_vec
    localparam logic FIXED = (v >= `IVP_VEC_FIRST_SRC) &&
                             (v <= `IVP_VEC_FIXED_END);
    localparam logic PROG  = ((v >= `IVP_VEC_PROG_LO) &&
                              (v <= `IVP_VEC_PROG_HI)) ||
                             (v == `IVP_VEC_LVD) || (v == `IVP_VEC_PLL);
    // reset overlays and the reserved slot never take part
    assign src_mask[v] = (v >= `IVP_VEC_FIRST_SRC) &&
                         (v != `IVP_VEC_RSVD);
    logic [`IVP_LVL_W-1:0] cfg;
    assign cfg = prog_lvl_in[v*`IVP_LVL_W +: `IVP_LVL_W];
    always_comb
    begin
      if (FIXED)
        eff_lvl[v*`IVP_LVL_W +: `IVP_LVL_W] = `IVP_LVL_FIXED;
      else if (PROG)
        // a level below one is clamped rather than silently disabling
        eff_lvl[v*`IVP_LVL_W +: `IVP_LVL_W] =
          (cfg < `IVP_LVL_PROG_MIN) ? `IVP_LVL_PROG_MIN : cfg;
      else if (v == `IVP_VEC_SW2)
        eff_lvl[v*`IVP_LVL_W +: `IVP_LVL_W] = `IVP_LVL_SW2;
      else if (v == `IVP_VEC_SW1)
        eff_lvl[v*`IVP_LVL_W +: `IVP_LVL_W] = `IVP_LVL_SW1;
      else
        eff_lvl[v*`IVP_LVL_W +: `IVP_LVL_W] = `IVP_LVL_SW0;
    end
  end

  assign pend = req_in & src_mask;

  ivp_arbiter #(
    .NUM_VEC (`IVP_NUM_VEC)
  ) u_arb (
    .pend_in (pend),
    .lvl_in  (eff_lvl),
    .hit_out (hit),
    .vec_out (win_vec),
    .lvl_out (win_lvl)
  );

  always_comb
  begin
    next_state   = state;
    next_irq     = irq_out;
    next_vec     = vec_out;
    next_lvl     = lvl_out;
    next_addr    = entry_addr_out;
    next_ack_vec = 1'b0;
    case (state)
      IVP_IDLE:
      begin
        if (chip_rst_req_in || wdog_rst_req_in)
        begin
          // reset causes fetch entries 0 and 1 and bypass arbitration
          next_vec  = wdog_rst_req_in && !chip_rst_req_in ?
                      `IVP_VEC_W'(1) : '0;
          next_lvl  = `IVP_LVL_FIXED;
          // sum is kept to the address width; the table wraps at the top
          next_addr = `IVP_ADDR_W'(vector_base_in +
                      (`IVP_ADDR_W'(next_vec) * `IVP_ENTRY_WORDS));
          next_irq  = 1'b1;
          next_state = IVP_OFFER;
        end
        else if (hit)
        begin
          next_vec  = win_vec;
          next_lvl  = win_lvl;
          // two words per entry gives offset = vector * 2
          next_addr = `IVP_ADDR_W'(vector_base_in +
                      (`IVP_ADDR_W'(win_vec) * `IVP_ENTRY_WORDS));
          next_irq  = 1'b1;
          next_state = IVP_OFFER;
        end
      end
      IVP_OFFER:
      begin
        // offer is held stable until the core takes it
        if (ack_in)
        begin
          next_irq     = 1'b0;
          next_ack_vec = 1'b1;
          next_state   = IVP_ACKED;
        end
      end
      IVP_ACKED:
      begin
        // one idle cycle lets the source drop its request
        next_state = IVP_IDLE;
      end
      default:
      begin
        next_state = IVP_IDLE;
        next_irq   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state          <= IVP_IDLE;
      irq_out        <= 1'b0;
      vec_out        <= '0;
      lvl_out        <= '0;
      entry_addr_out <= `IVP_BASE_RESET;
      ack_vec_out    <= 1'b0;
    end
    else if (clk_en_in)
    begin
      state          <= next_state;
      irq_out        <= next_irq;
      vec_out        <= next_vec;
      lvl_out        <= next_lvl;
      entry_addr_out <= next_addr;
      ack_vec_out    <= next_ack_vec;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_offer_ord;
    clk_en_in && state == IVP_IDLE && hit &&
    !chip_rst_req_in && !wdog_rst_req_in;
  endsequence

  property p_top_level;
    s_offer_ord |=> irq_out && vec_out == $past(win_vec);
  endproperty
  a_top_level: assert property (p_top_level)
    else $error("winner not presented");

  property p_no_lower_lost;
    irq_out && vec_out >= `IVP_VEC_FIRST_SRC |->
      lvl_out != `IVP_LVL_W'(0) || vec_out == `IVP_VEC_SW0;
  endproperty
  a_no_lower_lost: assert property (p_no_lower_lost)
    else $error("level zero on non level-zero vector");

  property p_addr;
    irq_out |-> entry_addr_out == `IVP_ADDR_W'($past(vector_base_in) +
      `IVP_ADDR_W'(vec_out) * `IVP_ENTRY_WORDS);
  endproperty
  a_addr: assert property (p_addr)
    else $error("entry address mismatch");

  property p_rst_vec;
    clk_en_in && state == IVP_IDLE && chip_rst_req_in |=> vec_out == '0;
  endproperty
  a_rst_vec: assert property (p_rst_vec)
    else $error("chip reset not on vector zero");

  property p_no_overlay;
    s_offer_ord |=> vec_out >= `IVP_VEC_FIRST_SRC;
  endproperty
  a_no_overlay: assert property (p_no_overlay)
    else $error("source used reset overlay");

  property p_fixed_lvl;
    irq_out && vec_out >= `IVP_VEC_FIRST_SRC &&
    vec_out <= `IVP_VEC_FIXED_END |-> lvl_out == `IVP_LVL_FIXED;
  endproperty
  a_fixed_lvl: assert property (p_fixed_lvl)
    else $error("fixed vector not at level three");

  property p_prog_min;
    irq_out && ((vec_out >= `IVP_VEC_PROG_LO &&
    vec_out <= `IVP_VEC_PROG_HI) || vec_out == `IVP_VEC_LVD ||
    vec_out == `IVP_VEC_PLL) |-> lvl_out >= `IVP_LVL_PROG_MIN;
  endproperty
  a_prog_min: assert property (p_prog_min)
    else $error("programmable level below one");

  property p_no_rsvd;
    irq_out |-> vec_out != `IVP_VEC_RSVD;
  endproperty
  a_no_rsvd: assert property (p_no_rsvd)
    else $error("reserved vector raised");

  property p_hold;
    irq_out && !ack_in && clk_en_in |=> irq_out && $stable(vec_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("offer changed before ack");
endmodule

/* File: hw/ivp_pkg.sv */
// Purpose: shared types for the interrupt vector priority block
// Assumes: constants come from ivp_regs.svh
// Notes:   none
`include "ivp_regs.svh"
package ivp_pkg;
  typedef logic [`IVP_VEC_W-1:0]  ivp_vec_t;
  typedef logic [`IVP_LVL_W-1:0]  ivp_lvl_t;
  typedef logic [`IVP_ADDR_W-1:0] ivp_addr_t;
  typedef enum logic [2:0]
  {
    IVP_IDLE  = 3'h1,
    IVP_OFFER = 3'h2,
    IVP_ACKED = 3'h4
  } ivp_state_t;
endpackage

/* File: hw/ivp_regs.svh */
// Purpose: constants for the interrupt vector priority block
// Assumes: vectors 0..16, word-addressed program space
// Notes:   offsets are in program words relative to the vector base
`ifndef IVP_REGS_SVH
`define IVP_REGS_SVH
`define IVP_NUM_VEC       17
`define IVP_VEC_W         5
`define IVP_LVL_W         2
`define IVP_ADDR_W        21
`define IVP_HANDLER_W     19
`define IVP_ENTRY_WORDS   2
`define IVP_VEC_FIRST_SRC 2
`define IVP_VEC_FIXED_END 5
`define IVP_VEC_PROG_LO   6
`define IVP_VEC_PROG_HI   10
`define IVP_VEC_SW2       11
`define IVP_VEC_SW1       12
`define IVP_VEC_SW0       13
`define IVP_VEC_RSVD      14
`define IVP_VEC_LVD       15
`define IVP_VEC_PLL       16
`define IVP_LVL_FIXED     2'h3
`define IVP_LVL_SW2       2'h2
`define IVP_LVL_SW1       2'h1
`define IVP_LVL_SW0       2'h0
`define IVP_LVL_PROG_MIN  2'h1
`define IVP_BASE_RESET    21'h000000
`endif
